/* logic/power_up_sequencer.sv */
// power-up sequencer: event qualification, slotted enables, apb registers
`timescale 1ns/1ns
`default_nettype none
`include "pwrseq_consts.svh"
module power_up_sequencer #(
    parameter int NREG = `NUM_REGS
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic supply_ok,
    input wire logic over_temp,
    input wire logic trim_fault_flag,
    input wire logic fuse_fault_flag,
    input wire logic self_test_fault_flag,
    input wire logic power_on_request_pin,
    input wire logic power_on_edge_mode,
    input wire logic power_good_gpo_mode,
    input wire logic [1:0] sequencer_time_base_default,
    input wire logic [7:0] regulator_slot_code_default [NREG],
    input wire logic [7:0] power_good_slot_code_default,
    input wire logic [7:0] host_reset_slot_code_default,
    output logic [NREG-1:0] regulator_enable,
    output logic power_good_pin,
    output logic host_reset_n
);
    import pwrseq_pkg::*;

    localparam int TB0 = `TB_00_US * `CLK_MHZ;
    localparam int TB1 = `TB_01_US * `CLK_MHZ;
    localparam int TB2 = `TB_10_US * `CLK_MHZ;
    localparam int TB3 = `TB_11_US * `CLK_MHZ;
    localparam int DBNC_CYC = `DBNC_US * `CLK_MHZ;
    localparam int LOAD_CYC = `FUSELOAD_US * `CLK_MHZ / 2;
    localparam int TEST_CYC = `SELFTEST_US * `CLK_MHZ;

    // slot and standby maps only have room for three rails
    if (NREG < 1 || NREG > 3) begin : g_nreg_bad
        $error("NREG must be 1..3");
    end

    seq_state_t state_r;
    logic [2:0] sup_sync_r, pin_sync_r;
    logic sup_r, pin_r, pin_prev_r;
    logic lpm_sel_r, pudone_r, load_done_r, slave_r;
    logic [1:0] tbase_r;
    logic [7:0] reg_slot_r [NREG];
    logic [7:0] pg_slot_r, rst_slot_r;
    logic [NREG-1:0] stby_en_r;
    logic stby_req_r;
    logic [15:0] dbnc_cnt_r;
    logic dbnc_arm_r;
    logic [15:0] tmr_r;
    logic [14:0] tb_cnt_r;
    logic [7:0] slot_r;
    logic [NREG-1:0] reg_en_r;
    logic pg_r, rst_r;
    logic [31:0] prdata_r;
    logic pready_r, pslverr_r;

    logic [14:0] tb_len;
    logic req_event, event_ok, tb_tick, seq_done;
    logic [7:0] last_slot;
    logic any_slot;
    logic [NREG-1:0] run_mask;
    logic wr, rd;

    // three-stage synchronisers; change counts when stages 2 and 3 agree
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sup_sync_r <= 3'b000;
            pin_sync_r <= 3'b000;
            sup_r <= 1'b0;
            pin_r <= 1'b0;
        end else begin
            sup_sync_r <= {sup_sync_r[1:0], supply_ok};
            pin_sync_r <= {pin_sync_r[1:0], power_on_request_pin};
            if (sup_sync_r[1] == sup_sync_r[2])
                sup_r <= sup_sync_r[2];
            if (pin_sync_r[1] == pin_sync_r[2])
                pin_r <= pin_sync_r[2];
        end
    end

    // edge-mode debounce: armed on a falling edge, fires after hold time
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_prev_r <= 1'b0;
            dbnc_arm_r <= 1'b0;
            dbnc_cnt_r <= 16'h0000;
        end else begin
            pin_prev_r <= pin_r;
            if (pin_prev_r && !pin_r) begin
                dbnc_arm_r <= 1'b1;
                dbnc_cnt_r <= 16'h0000;
            end else if (pin_r) begin
                dbnc_arm_r <= 1'b0;
            end else if (dbnc_arm_r && dbnc_cnt_r != 16'(DBNC_CYC)) begin
                dbnc_cnt_r <= dbnc_cnt_r + 16'h0001;
            end
        end
    end

    // power-up event by pin mode
    always_comb begin
        if (power_on_edge_mode)
            req_event = dbnc_arm_r && dbnc_cnt_r == 16'(DBNC_CYC);
        else
            req_event = pin_r;
    end

    // qualification against supply, temperature and fault flags
    assign event_ok = sup_r && !over_temp && !trim_fault_flag
        && !fuse_fault_flag && !self_test_fault_flag;

    // time base decode
    always_comb begin
        unique case (tbase_r)
            2'b00: tb_len = 15'(TB0);
            2'b01: tb_len = 15'(TB1);
            2'b10: tb_len = 15'(TB2);
            2'b11: tb_len = 15'(TB3);
        endcase
    end

    assign tb_tick = tb_cnt_r == tb_len - 15'h0001;

    // latest programmed regulator/gpo/host-reset slot code
    always_comb begin
        last_slot = 8'h00;
        run_mask = '0;
        for (int i = 0; i < NREG; i++) begin
            run_mask[i] = reg_slot_r[i] != 8'h00;
            if (reg_slot_r[i] > last_slot)
                last_slot = reg_slot_r[i];
        end
        any_slot = last_slot != 8'h00
            || (power_good_gpo_mode && pg_slot_r != 8'h00);
        if (power_good_gpo_mode && pg_slot_r > last_slot)
            last_slot = pg_slot_r;
        if (rst_slot_r > last_slot)
            last_slot = rst_slot_r;
    end

    // sequence is over once the slot counter has reached one below the last code
    assign seq_done = slot_r + 8'h01 >= last_slot;

    assign wr = psel && penable && pwrite;
    assign rd = psel && !penable && !pwrite;

    // main state machine; timers run off the single clock
    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_r <= ST_UNPOWERED;
            tmr_r <= 16'h0000;
            tb_cnt_r <= 15'h0000;
            slot_r <= 8'h00;
            load_done_r <= 1'b0;
            slave_r <= 1'b0;
        end else if (!sup_r) begin
            state_r <= ST_UNPOWERED;
            load_done_r <= 1'b0;
            tmr_r <= 16'h0000;
        end else begin
            unique case (state_r)
                ST_UNPOWERED: begin
                    state_r <= ST_FUSE_LOAD;
                    tmr_r <= 16'h0000;
                end
                ST_FUSE_LOAD: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_r == 16'(LOAD_CYC)) begin
                        load_done_r <= 1'b1;
                        state_r <= ST_LOW_POWER_OFF_STATE;
                    end
                end
                ST_LOW_POWER_OFF_STATE: begin
                    tmr_r <= 16'h0000;
                    slot_r <= 8'h00;
                    tb_cnt_r <= 15'h0000;
                    if (req_event && event_ok) begin
                        // low-power off must bias up and self-test first unless lpm_sel_r is set
                        if (lpm_sel_r)
                            state_r <= ST_SEQUENCE;
                        else
                            state_r <= ST_SELF_TEST;
                    end
                end
                ST_SELF_TEST: begin
                    tmr_r <= tmr_r + 16'h0001;
                    if (tmr_r == 16'(TEST_CYC)) begin
                        if (event_ok)
                            state_r <= ST_SEQUENCE;
                        else
                            state_r <= ST_LOW_POWER_OFF_STATE;
                    end
                end
                ST_SEQUENCE: begin
                    slave_r <= !any_slot;
                    if (seq_done) begin
                        state_r <= ST_RUN;
                    end else if (tb_tick) begin
                        tb_cnt_r <= 15'h0000;
                        slot_r <= slot_r + 8'h01;
                    end else begin
                        tb_cnt_r <= tb_cnt_r + 15'h0001;
                    end
                end
                ST_RUN: begin
                    if (stby_req_r)
                        state_r <= ST_STANDBY;
                    else if (!pin_r && !power_on_edge_mode)
                        state_r <= ST_LOW_POWER_OFF_STATE;
                end
                ST_STANDBY: begin
                    slot_r <= 8'h00;
                    tb_cnt_r <= 15'h0000;
                    if (!stby_req_r) begin
                        // re-sequence only if a rail turns back on
                        if (|(run_mask & ~reg_en_r))
                            state_r <= ST_SEQUENCE;
                        else
                            state_r <= ST_RUN;
                    end
                end
                default: state_r <= ST_UNPOWERED;
            endcase
        end
    end

    // output enables; equal codes match in the same cycle
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_en_r <= '0;
            pg_r <= 1'b0;
            rst_r <= 1'b0;
        end else if (state_r == ST_SEQUENCE) begin
            for (int i = 0; i < NREG; i++) begin
                if (reg_slot_r[i] != 8'h00 && reg_slot_r[i] - 8'h01 <= slot_r)
                    reg_en_r[i] <= 1'b1;
            end
            if (power_good_gpo_mode && pg_slot_r != 8'h00
                && pg_slot_r - 8'h01 <= slot_r)
                pg_r <= 1'b1;
            if (rst_slot_r != 8'h00 && rst_slot_r - 8'h01 <= slot_r)
                rst_r <= 1'b1;
            else if (rst_slot_r == 8'h00 && seq_done)
                rst_r <= 1'b1;
        end else if (state_r == ST_RUN) begin
            if (rst_slot_r == 8'h00)
                rst_r <= 1'b1;
        end else if (state_r == ST_STANDBY) begin
            reg_en_r <= reg_en_r & stby_en_r;
        end else begin
            reg_en_r <= '0;
            pg_r <= 1'b0;
            rst_r <= 1'b0;
        end
    end

    // configuration: fuse reload in off modes, writes while on
    always_ff @(posedge clk) begin
        if (!nrst) begin
            tbase_r <= 2'b00;
            for (int i = 0; i < NREG; i++)
                reg_slot_r[i] <= 8'h00;
            pg_slot_r <= 8'h00;
            rst_slot_r <= 8'h00;
        end else if (state_r == ST_LOW_POWER_OFF_STATE || state_r == ST_FUSE_LOAD) begin
            tbase_r <= sequencer_time_base_default;
            for (int i = 0; i < NREG; i++)
                reg_slot_r[i] <= regulator_slot_code_default[i];
            pg_slot_r <= power_good_slot_code_default;
            rst_slot_r <= host_reset_slot_code_default;
        end else if (wr && (state_r == ST_RUN || state_r == ST_STANDBY)) begin
            unique case (paddr)
                `ADDR_TBASE: tbase_r <= pwdata[1:0];
                `ADDR_SLOT_REG0: reg_slot_r[0] <= pwdata[7:0];
                `ADDR_SLOT_REG1: if (NREG > 1) reg_slot_r[1] <= pwdata[7:0];
                `ADDR_SLOT_REG2: if (NREG > 2) reg_slot_r[2] <= pwdata[7:0];
                `ADDR_SLOT_PG: pg_slot_r <= pwdata[7:0];
                `ADDR_SLOT_RST: rst_slot_r <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // select bit, standby control and power-up-done flag
    always_ff @(posedge clk) begin
        if (!nrst) begin
            lpm_sel_r <= 1'b0;
            stby_req_r <= 1'b0;
            stby_en_r <= '0;
            pudone_r <= 1'b0;
        end else begin
            if (state_r == ST_UNPOWERED)
                lpm_sel_r <= 1'b0;
            else if (wr && paddr == `ADDR_CTRL && state_r == ST_RUN)
                lpm_sel_r <= pwdata[`CTRL_LPM_BIT];
            if (wr && paddr == `ADDR_STBY) begin
                stby_req_r <= pwdata[31];
                stby_en_r <= pwdata[NREG-1:0];
            end
            if (state_r == ST_LOW_POWER_OFF_STATE)
                stby_req_r <= 1'b0;
            // set wins over a simultaneous clear
            if (state_r == ST_STANDBY && !stby_req_r)
                pudone_r <= 1'b1;
            else if (wr && paddr == `ADDR_CTRL
                && pwdata[`CTRL_PUDONE_CLR_BIT])
                pudone_r <= 1'b0;
        end
    end

    // apb slave: zero wait, read data captured in setup phase
    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata_r <= 32'h00000000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            pready_r <= psel && !penable;
            pslverr_r <= 1'b0;
            if (rd) begin
                unique case (paddr)
                    `ADDR_CTRL: prdata_r <= {31'h0, lpm_sel_r};
                    `ADDR_TBASE: prdata_r <= {30'h0, tbase_r};
                    `ADDR_SLOT_REG0: prdata_r <= {24'h0, reg_slot_r[0]};
                    `ADDR_SLOT_REG1:
                        prdata_r <= NREG > 1 ? {24'h0, reg_slot_r[1]} : '0;
                    `ADDR_SLOT_REG2:
                        prdata_r <= NREG > 2 ? {24'h0, reg_slot_r[2]} : '0;
                    `ADDR_SLOT_PG: prdata_r <= {24'h0, pg_slot_r};
                    `ADDR_SLOT_RST: prdata_r <= {24'h0, rst_slot_r};
                    `ADDR_STATUS: prdata_r <= {26'h0, lpm_sel_r,
                        state_r == ST_STANDBY, slave_r, state_r == ST_RUN,
                        pudone_r, load_done_r};
                    `ADDR_STBY: prdata_r <= {stby_req_r, 28'h0,
                        3'(stby_en_r)};
                    default: begin
                        prdata_r <= 32'h00000000;
                        pslverr_r <= 1'b1;
                    end
                endcase
            end else if (psel && !penable) begin
                prdata_r <= 32'h00000000;
                pslverr_r <= !(paddr inside {`ADDR_CTRL, `ADDR_TBASE,
                    `ADDR_SLOT_REG0, `ADDR_SLOT_REG1, `ADDR_SLOT_REG2,
                    `ADDR_SLOT_PG, `ADDR_SLOT_RST, `ADDR_STATUS,
                    `ADDR_STBY});
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign regulator_enable = reg_en_r;
    assign power_good_pin = pg_r;
    assign host_reset_n = rst_r;
endmodule
`default_nettype wire

/* logic/pwrseq_consts.svh */
// timing values in us and MHz, field positions and register offsets of the power-up sequencer
`ifndef PWRSEQ_CONSTS_SVH
`define PWRSEQ_CONSTS_SVH
`define CLK_MHZ 50
`define TB_00_US 30
`define TB_01_US 120
`define TB_10_US 250
`define TB_11_US 500
`define DBNC_US 30
`define FUSELOAD_US 600
`define SELFTEST_US 200
`define NUM_REGS 3
// register byte offsets
`define ADDR_CTRL 12'h000
`define ADDR_TBASE 12'h004
`define ADDR_SLOT_REG0 12'h008
`define ADDR_SLOT_REG1 12'h00c
`define ADDR_SLOT_REG2 12'h010
`define ADDR_SLOT_PG 12'h014
`define ADDR_SLOT_RST 12'h018
`define ADDR_STATUS 12'h01c
`define ADDR_STBY 12'h020
// ctrl and status bits
`define CTRL_LPM_BIT 0
`define CTRL_PUDONE_CLR_BIT 1
`define STATUS_LOAD_DONE_BIT 0
`define STATUS_PUDONE_BIT 1
`define STATUS_RUN_BIT 2
`define STATUS_SLAVE_BIT 3
`define STATUS_STBY_BIT 4
`define STATUS_LPM_BIT 5
`endif

/* logic/pwrseq_pkg.sv */
// types of the power-up sequencer
package pwrseq_pkg;
    typedef enum logic [2:0] {
        ST_UNPOWERED = 3'b000,
        ST_FUSE_LOAD = 3'b001,
        ST_LOW_POWER_OFF_STATE = 3'b011,
        ST_SELF_TEST = 3'b010,
        ST_SEQUENCE = 3'b110,
        ST_RUN = 3'b111,
        ST_STANDBY = 3'b101
    } seq_state_t;
endpackage

/* sim/pwrseq_monitor.sv */
// concurrent checks on the power-up sequencer ports
`timescale 1ns/1ns
`default_nettype none
`include "pwrseq_consts.svh"
module pwrseq_monitor #(
    parameter int NREG = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic over_temp,
    input wire logic trim_fault_flag,
    input wire logic fuse_fault_flag,
    input wire logic self_test_fault_flag,
    input wire logic [1:0] sequencer_time_base_default,
    input wire logic [7:0] regulator_slot_code_default [NREG],
    input wire logic [7:0] power_good_slot_code_default,
    input wire logic [7:0] host_reset_slot_code_default,
    input wire logic [NREG-1:0] regulator_enable,
    input wire logic power_good_pin,
    input wire logic host_reset_n
);
    localparam int SLOT_GAP = `TB_00_US * `CLK_MHZ;
    logic [15:0] since_en0_r;
    // cycles since regulator 0 came on; saturates so it never wraps
    always_ff @(posedge clk) begin
        if (!nrst || !regulator_enable[0]) begin
            since_en0_r <= 16'h0000;
        end else if (since_en0_r != 16'hffff) begin
            since_en0_r <= since_en0_r + 16'h0001;
        end
    end
    chk_reset_outs: assert property (@(posedge clk) !nrst |=>
        regulator_enable == '0 && !power_good_pin && !host_reset_n)
        else $error("outputs not cleared by reset");
    chk_ready_access: assert property (@(posedge clk) disable iff (!nrst)
        psel && !penable |=> pready && psel && penable)
        else $error("no ready in access phase");
    chk_ready_alone: assert property (@(posedge clk) disable iff (!nrst)
        pready |-> psel && penable && $past(psel) && !$past(penable))
        else $error("ready outside access phase");
    chk_unmapped_err: assert property (@(posedge clk) disable iff (!nrst)
        psel && !penable && paddr > 12'h020 |=> pslverr && prdata == '0)
        else $error("unmapped access not refused");
    chk_fault_block: assert property (@(posedge clk) disable iff (!nrst)
        $rose(|regulator_enable) |-> !(over_temp || trim_fault_flag ||
        fuse_fault_flag || self_test_fault_flag))
        else $error("power-up despite fault");
    chk_zero_code: assert property (@(posedge clk) disable iff (!nrst)
        $rose(power_good_pin) |-> power_good_slot_code_default != 8'h00)
        else $error("power-good raised with zero slot");
    chk_slot_gap: assert property (@(posedge clk) disable iff (!nrst)
        $rose(regulator_enable[1]) && sequencer_time_base_default == 2'h0 &&
        regulator_slot_code_default[1] == regulator_slot_code_default[0]
        + 8'h01 |-> since_en0_r == SLOT_GAP)
        else $error("slot spacing wrong");
    chk_same_slot: assert property (@(posedge clk) disable iff (!nrst)
        $rose(regulator_enable[1]) && regulator_slot_code_default[1] ==
        regulator_slot_code_default[2] |-> $rose(regulator_enable[2]))
        else $error("equal slots apart");
    chk_reset_last: assert property (@(posedge clk) disable iff (!nrst)
        $rose(host_reset_n) && host_reset_slot_code_default == 8'h00 |->
        (regulator_enable[0] || regulator_slot_code_default[0] == 8'h00) &&
        (regulator_enable[1] || regulator_slot_code_default[1] == 8'h00) &&
        (regulator_enable[2] || regulator_slot_code_default[2] == 8'h00))
        else $error("host reset let go early");
endmodule
bind power_up_sequencer pwrseq_monitor #(.NREG(NREG)) mon (.clk(clk),
    .nrst(nrst), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .over_temp(over_temp), .trim_fault_flag(trim_fault_flag),
    .fuse_fault_flag(fuse_fault_flag),
    .self_test_fault_flag(self_test_fault_flag),
    .sequencer_time_base_default(sequencer_time_base_default),
    .regulator_slot_code_default(regulator_slot_code_default),
    .power_good_slot_code_default(power_good_slot_code_default),
    .host_reset_slot_code_default(host_reset_slot_code_default),
    .regulator_enable(regulator_enable), .power_good_pin(power_good_pin),
    .host_reset_n(host_reset_n));
`default_nettype wire

/* sim/supply_host_model.sv */
// supply rail and host model on the far side of the sequencer
`timescale 1ns/1ns
`default_nettype none
module supply_host_model #(
    parameter int RAMP = 20
) (
    input wire logic clk,
    input wire logic power_applied,
    input wire logic host_reset_n,
    output logic supply_ok,
    output logic host_running
);
    int ramp_r;
    // rail ramps a while before crossing the threshold, drops at once
    always_ff @(posedge clk) begin
        if (!power_applied) begin
            ramp_r <= 0;
        end else if (ramp_r < RAMP) begin
            ramp_r <= ramp_r + 1;
        end
    end
    assign supply_ok = power_applied && ramp_r == RAMP;
    // host only runs once its reset is let go on a live rail
    always_ff @(posedge clk) begin
        host_running <= host_reset_n && supply_ok;
    end
endmodule
`default_nettype wire

/* sim/tb_top.sv */
// self-checking bench for the power-up sequencer
`timescale 1ns/1ns
`default_nettype none
`include "pwrseq_consts.svh"
module tb_top;
    import pwrseq_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, power_applied = 1'b0, pin = 1'b1, edge_mode = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, supply_ok, host_running, pg, rst_n, err;
    logic [3:0] faults = 4'h0;
    logic [1:0] tb_def = 2'h0;
    logic [7:0] reg_def [3] = '{8'h01, 8'h02, 8'h02};
    logic [7:0] pg_def = 8'h03;
    logic [2:0] en;
    int n_errors = 0, samples_checked = 0, cycles = 0, n, f;

    always #10 clk = ~clk;
    power_up_sequencer #(.NREG(3)) DUT (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .supply_ok(supply_ok), .over_temp(faults[0]),
        .trim_fault_flag(faults[1]), .fuse_fault_flag(faults[2]),
        .self_test_fault_flag(faults[3]), .power_on_request_pin(pin),
        .power_on_edge_mode(edge_mode), .power_good_gpo_mode(1'b1),
        .sequencer_time_base_default(tb_def),
        .regulator_slot_code_default(reg_def),
        .power_good_slot_code_default(pg_def),
        .host_reset_slot_code_default(8'h00), .regulator_enable(en),
        .power_good_pin(pg), .host_reset_n(rst_n));
    supply_host_model #(.RAMP(20)) rail (.clk(clk),
        .power_applied(power_applied), .host_reset_n(rst_n),
        .supply_ok(supply_ok), .host_running(host_running));

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // one apb transfer; request held until pready is seen at an edge,
    // only the hang guard ends a wait
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    function automatic logic sig(input int i);
        case (i)
            3: return pg;
            4: return rst_n;
            5: return ~|{en, pg};
            default: return en[i];
        endcase
    endfunction
    // cycles to wait per slot step at the 30 us time base
    function automatic int gap(input int slots);
        return slots * `TB_00_US * `CLK_MHZ;
    endfunction
    // bounded wait, leaves the cycle count in n
    task automatic wait_sig(input int i);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (sig(i) !== 1'b1 && n < 80000);
        chk("wait_done", 32'h1, 32'(sig(i)));
    endtask
    task automatic status();
        apb(1'b0, `ADDR_STATUS, 32'h0);
    endtask

    // hang guard, sized well above the longest expected run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 100000) begin
            n_errors++;
            finish_test();
        end
    end

    initial begin
        void'($urandom(9789));
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        power_applied <= 1'b1;
        wait_sig(0);
        chk("start_time", 32'h1, 32'(n <= 75000));
        wait_sig(1);
        chk("slot1_gap", gap(1), n);
        chk("same_slot", 32'h1, 32'(en[2]));
        wait_sig(3);
        chk("pg_gap", gap(1), n);
        wait_sig(4);
        chk("rst_after", 32'h7, 32'(en));
        @(posedge clk);
        #1;
        chk("host_up", 32'h1, 32'(host_running));
        status();
        chk("run", 32'h1, 32'(rd[`STATUS_RUN_BIT]));
        $display("test startup done");
        apb(1'b0, 12'h100, 32'h0);
        chk("unmapped_err", 32'h1, 32'(err));
        chk("unmapped_data", 32'h0, rd);
        apb(1'b1, `ADDR_SLOT_REG2, 32'h05);
        apb(1'b0, `ADDR_SLOT_REG2, 32'h0);
        chk("slot_write", 32'h5, rd);
        apb(1'b1, `ADDR_CTRL, 32'h1);
        status();
        chk("lpm_set", 32'h1, 32'(rd[`STATUS_LPM_BIT]));
        $display("test registers done");
        // off, then a refused request under one random fault
        pin <= 1'b0;
        wait_sig(5);
        f = $urandom % 4;
        @(posedge clk);
        faults <= 4'h1 << f;
        pin <= 1'b1;
        repeat (3000) @(posedge clk);
        #1;
        chk("fault_block", 32'h0, 32'(en));
        // fault stays until the low pin has reached the sequencer
        @(posedge clk);
        pin <= 1'b0;
        repeat (20) @(posedge clk);
        faults <= 4'h0;
        pin <= 1'b1;
        wait_sig(0);
        wait_sig(1);
        chk("reload", 32'h1, 32'(en[2]));
        status();
        chk("lpm_kept", 32'h1, 32'(rd[`STATUS_LPM_BIT]));
        $display("test fault done");
        // standby drops rail 2; leaving it must re-sequence that rail
        wait_sig(4);
        apb(1'b1, `ADDR_STBY, 32'h80000003);
        repeat (4) @(posedge clk);
        #1;
        chk("stby_drop", 32'h3, 32'(en));
        apb(1'b1, `ADDR_STBY, 32'h00000003);
        wait_sig(2);
        chk("stby_reseq", 32'h1, 32'(n >= gap(1) && n <= gap(1) + 8));
        repeat (1600) @(posedge clk);
        status();
        chk("stby_run", 32'h1, 32'(rd[`STATUS_RUN_BIT]));
        chk("pudone_seq", 32'h1, 32'(rd[`STATUS_PUDONE_BIT]));
        apb(1'b1, `ADDR_CTRL, 32'h3);
        status();
        chk("pudone_clr", 32'h0, 32'(rd[`STATUS_PUDONE_BIT]));
        // keep-all standby changes no rail and returns at once
        apb(1'b1, `ADDR_STBY, 32'h80000007);
        apb(1'b1, `ADDR_STBY, 32'h00000007);
        repeat (3) @(posedge clk);
        #1;
        chk("stby_direct", 32'h7, 32'(en));
        status();
        chk("direct_run", 32'h1, 32'(rd[`STATUS_RUN_BIT]));
        chk("pudone_direct", 32'h1, 32'(rd[`STATUS_PUDONE_BIT]));
        $display("test standby done");
        // all codes zero: slave-mode run, reset let go, nothing on
        pin <= 1'b0;
        reg_def <= '{8'h00, 8'h00, 8'h00};
        pg_def <= 8'h00;
        wait_sig(5);
        @(posedge clk);
        pin <= 1'b1;
        repeat (20) @(posedge clk);
        status();
        chk("slave", 32'h1, 32'(rd[`STATUS_SLAVE_BIT]));
        chk("slave_run", 32'h1, 32'(rd[`STATUS_RUN_BIT]));
        chk("slave_outs", 32'h10, 32'({rst_n, pg, en}));
        reg_def <= '{8'h01, 8'h02, 8'h02};
        pg_def <= 8'h03;
        $display("test slave done");
        // supply cycle, then edge mode with a short and a long low
        pin <= 1'b0;
        wait_sig(5);
        @(posedge clk);
        power_applied <= 1'b0;
        edge_mode <= 1'b1;
        pin <= 1'b1;
        repeat (50) @(posedge clk);
        power_applied <= 1'b1;
        repeat (16000) @(posedge clk);
        status();
        chk("load_done", 32'h1, 32'(rd[`STATUS_LOAD_DONE_BIT]));
        chk("lpm_clear", 32'h0, 32'(rd[`STATUS_LPM_BIT]));
        pin <= 1'b0;
        repeat ($urandom_range(1000, 100)) @(posedge clk);
        pin <= 1'b1;
        repeat (3000) @(posedge clk);
        #1;
        chk("short_low", 32'h0, 32'(en));
        @(posedge clk);
        pin <= 1'b0;
        wait_sig(0);
        chk("debounce", 32'h1, 32'(n > gap(1)));
        chk("wake_time", 32'h1, 32'(n <= 40000));
        $display("test edge mode done");
        finish_test();
    end
endmodule
`default_nettype wire
